//--- rtl/phy_ctrl_defines.svh
`ifndef PHY_CTRL_DEFINES_SVH
`define PHY_CTRL_DEFINES_SVH

// register word addresses on the management port
`define ADDR_PHY_SPECIFIC_CONTROL 5'h11
`define ADDR_EVT_STATUS           5'h18
`define ADDR_EVT_CLEAR            5'h19
`define ADDR_EVT_ENABLE           5'h1a

// control word layout
`define BIT_SCRAMBLER_BYPASS      11
`define BIT_FIFO_DEPTH_HI         9
`define BIT_FIFO_DEPTH_LO         8
`define BIT_FD_COLLISION_ENABLE   4
`define BIT_INTERRUPT_POLARITY    3
`define BIT_TEST_INTERRUPT        2
`define BIT_INTERRUPT_ENABLE      1
`define BIT_INTERRUPT_PIN_SELECT  0

`define CONTROL_RESET             16'h0108
`define CONTROL_WRITE_MASK        16'h0b1f

// elastic buffer depths in nibbles
`define FIFO_SLOTS                4'h8
`define FIFO_DEPTH_CODE0          4'h4
`define FIFO_DEPTH_CODE1          4'h5
`define FIFO_DEPTH_CODE2          4'h6
`define FIFO_DEPTH_CODE3          4'h8

// event bits
`define EVT_WIDTH                 3
`define EVT_FIFO_OVERRUN          0
`define EVT_FIFO_UNDERRUN         1
`define EVT_COLLISION             2

`define SCRAMBLER_SEED            11'h7ff

`endif

//--- rtl/phy_ctrl_pkg.sv
package phy_ctrl_pkg;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
    } regReq_type;

    typedef struct packed {
        logic [4:0] symbol;
        logic       valid;
    } txSymbol_type;

    typedef struct packed {
        logic [3:0] nibble;
        logic       valid;
    } nibble_type;

    typedef enum logic [1:0] {
        FIFO_IDLE    = 2'b00,
        FIFO_FILLING = 2'b01,
        FIFO_RUNNING = 2'b11
    } fifoState_type;

endpackage

//--- rtl/phy_specific_control_bits.sv
// Operation
// - bypass bit set skips 100Base-TX scrambling
// - reserved bits 10, 7:5 read zero
// - depth field resets to code 01
// - loopback nibbles pass through elastic FIFO
// - full-duplex collision only when enable set
// - polarity resets 1, selects pin idle level
// - test bit forces continuous interrupt
// - interrupt reaches pin only when selected
`timescale 1ns/1ps
`default_nettype none
`include "phy_ctrl_defines.svh"

module phy_specific_control_bits (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      ce,
    input  wire phy_ctrl_pkg::regReq_type  regReq,
    output var  logic [15:0]               regRdata,
    input  wire phy_ctrl_pkg::txSymbol_type txIn,
    output var  phy_ctrl_pkg::txSymbol_type txOut,
    input  wire logic                      loopbackEnable,
    input  wire phy_ctrl_pkg::nibble_type  rxNibble,
    input  wire logic                      txNibbleTake,
    output var  phy_ctrl_pkg::nibble_type  txNibble,
    input  wire logic                      collisionDetect,
    input  wire logic                      fullDuplex,
    output logic                           collisionOut,
    input  wire logic                      phyEventIrq,
    input  wire logic                      intPinIn,
    output logic                           intPinOut,
    output logic                           intPinOen,
    output logic                           powerDownReq,
    output logic                           irq
);
    import phy_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register port decode

    logic [15:0]           control;
    logic [`EVT_WIDTH-1:0] evtStatus;
    logic [`EVT_WIDTH-1:0] evtEnable;
    logic [`EVT_WIDTH-1:0] evtSet;

    wire hitControl = regReq.addr == `ADDR_PHY_SPECIFIC_CONTROL;
    wire hitStatus  = regReq.addr == `ADDR_EVT_STATUS;
    wire hitClear   = regReq.addr == `ADDR_EVT_CLEAR;
    wire hitEnable  = regReq.addr == `ADDR_EVT_ENABLE;

    wire writeControl = regReq.write && hitControl;
    wire writeClear   = regReq.write && hitClear;
    wire writeEnable  = regReq.write && hitEnable;

    wire scramblerBypass = control[`BIT_SCRAMBLER_BYPASS];
    wire [1:0] depthCode = control[`BIT_FIFO_DEPTH_HI:`BIT_FIFO_DEPTH_LO];
    wire fdCollisionEnable = control[`BIT_FD_COLLISION_ENABLE];
    wire interruptPolarity = control[`BIT_INTERRUPT_POLARITY];
    wire testInterrupt     = control[`BIT_TEST_INTERRUPT];
    wire interruptEnable   = control[`BIT_INTERRUPT_ENABLE];
    wire pinSelect         = control[`BIT_INTERRUPT_PIN_SELECT];

    // reserved zeroed
    // masking on write keeps reserved positions zero in storage as well
    wire [15:0] next_control = regReq.wdata & `CONTROL_WRITE_MASK;

    wire [15:0] readMux =
        hitControl ? (control & `CONTROL_WRITE_MASK) :
        hitStatus  ? {13'h0000, evtStatus} :
        hitEnable  ? {13'h0000, evtEnable} :
        16'h0000;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            control <= `CONTROL_RESET;
        end else if (ce && writeControl) begin
            control <= next_control;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            regRdata <= 16'h0000;
        end else if (ce) begin
            regRdata <= regReq.read ? readMux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // event status, enable, interrupt

    // set wins over a clear in the same cycle so no event is lost
    wire [`EVT_WIDTH-1:0] clearBits = writeClear ? regReq.wdata[`EVT_WIDTH-1:0] : '0;
    wire [`EVT_WIDTH-1:0] next_evtStatus = (evtStatus & ~clearBits) | evtSet;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            evtStatus <= '0;
            evtEnable <= '0;
        end else if (ce) begin
            evtStatus <= next_evtStatus;
            if (writeEnable) begin
                evtEnable <= regReq.wdata[`EVT_WIDTH-1:0];
            end
        end
    end

    assign irq = |(evtStatus & evtEnable);

    wire intActive = testInterrupt || (interruptEnable && (phyEventIrq || irq));

    wire intLevel = interruptPolarity ? ~intActive : intActive;

    // shared pin: sampled through two flops, read only by the second
    logic pinSync1;
    logic pinSync2;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinSync1 <= 1'b1;
            pinSync2 <= 1'b1;
        end else if (ce) begin
            pinSync1 <= intPinIn;
            pinSync2 <= pinSync1;
        end
    end

    assign intPinOen = ~pinSelect;
    assign intPinOut = pinSelect ? intLevel : 1'b0;
    // power-down input is active low when the pin is not an output
    assign powerDownReq = ~pinSelect && ~pinSync2;

    ////////////////////////////////////////////////////////////////////////////
    // collision

    assign collisionOut = collisionDetect && (!fullDuplex || fdCollisionEnable);

    ////////////////////////////////////////////////////////////////////////////
    // transmit scrambler, x^11 + x^9 + 1, five bits per symbol

    logic [10:0] lfsr;
    logic [10:0] lfsrStep [0:5];
    logic [4:0]  keyStream;

    assign lfsrStep[0] = lfsr;
    generate
        for (genvar i = 0; i < 5; i++) begin : g_scr
            assign keyStream[i]  = lfsrStep[i][10] ^ lfsrStep[i][8];
            assign lfsrStep[i+1] = {lfsrStep[i][9:0], keyStream[i]};
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!nrst) begin
            lfsr <= `SCRAMBLER_SEED;
        end else if (ce && txIn.valid) begin
            lfsr <= lfsrStep[5];
        end
    end

    wire [4:0] next_symbol = scramblerBypass ? txIn.symbol : (txIn.symbol ^ keyStream);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txOut <= '0;
        end else if (ce) begin
            txOut.valid  <= txIn.valid;
            txOut.symbol <= txIn.valid ? next_symbol : 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // far-end loopback elastic buffer
    // rx side writes at the recovered rate, tx side takes at its own rate;
    // both arrive as strobes on this clock, the rate gap shows as fill drift

    logic [3:0]    fifoMem [0:7];
    logic [2:0]    wrPtr;
    logic [2:0]    rdPtr;
    logic [3:0]    fillCount;
    fifoState_type fifoState;
    fifoState_type next_fifoState;

    wire [3:0] depthNibbles =
        (depthCode == 2'b00) ? `FIFO_DEPTH_CODE0 :
        (depthCode == 2'b01) ? `FIFO_DEPTH_CODE1 :
        (depthCode == 2'b10) ? `FIFO_DEPTH_CODE2 :
        `FIFO_DEPTH_CODE3;

    wire fifoFull  = fillCount == `FIFO_SLOTS;
    wire fifoEmpty = fillCount == 4'h0;
    wire running   = fifoState == FIFO_RUNNING;

    wire doWrite  = loopbackEnable && rxNibble.valid && !fifoFull;
    wire doRead   = running && txNibbleTake && !fifoEmpty;
    wire overrun  = loopbackEnable && rxNibble.valid && fifoFull;
    wire underrun = running && txNibbleTake && fifoEmpty;

    wire [3:0] next_fillCount = fillCount + {3'b000, doWrite} - {3'b000, doRead};

    always_comb begin
        next_fifoState = fifoState;
        unique case (fifoState)
            FIFO_IDLE: begin
                if (loopbackEnable) begin
                    next_fifoState = FIFO_FILLING;
                end
            end
            FIFO_FILLING: begin
                if (!loopbackEnable) begin
                    next_fifoState = FIFO_IDLE;
                end else if (next_fillCount >= depthNibbles) begin
                    next_fifoState = FIFO_RUNNING;
                end
            end
            FIFO_RUNNING: begin
                if (!loopbackEnable) begin
                    next_fifoState = FIFO_IDLE;
                end else if (underrun) begin
                    next_fifoState = FIFO_FILLING;
                end
            end
            default: begin
                next_fifoState = FIFO_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fifoState <= FIFO_IDLE;
            wrPtr     <= 3'h0;
            rdPtr     <= 3'h0;
            fillCount <= 4'h0;
        end else if (ce) begin
            fifoState <= next_fifoState;
            if (!loopbackEnable) begin
                wrPtr     <= 3'h0;
                rdPtr     <= 3'h0;
                fillCount <= 4'h0;
            end else begin
                wrPtr     <= wrPtr + {2'b00, doWrite};
                rdPtr     <= rdPtr + {2'b00, doRead};
                fillCount <= next_fillCount;
            end
        end
    end

    // storage needs no reset; entries are only read after being written
    always_ff @(posedge clk) begin
        if (ce && doWrite) begin
            fifoMem[wrPtr] <= rxNibble.nibble;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            txNibble <= '0;
        end else if (ce) begin
            txNibble.valid  <= doRead;
            txNibble.nibble <= doRead ? fifoMem[rdPtr] : 4'h0;
        end
    end

    assign evtSet[`EVT_FIFO_OVERRUN]  = ce && overrun;
    assign evtSet[`EVT_FIFO_UNDERRUN] = ce && underrun;
    assign evtSet[`EVT_COLLISION]     = ce && collisionOut;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_reserved_read_zero: assert property (
        $past(regReq.read && hitControl && ce) && ce |-> (regRdata & 16'h04e0) == 16'h0000)
        else $error("reserved control bits read nonzero");

    chk_control_write_held: assert property (
        ce && writeControl |=> control == ($past(regReq.wdata) & `CONTROL_WRITE_MASK))
        else $error("control write not held");

    chk_depth_reset_value: assert property (
        $past(!nrst) |-> depthCode == 2'b01 && interruptPolarity && !testInterrupt)
        else $error("control reset value wrong");

    chk_depth_start_fill: assert property (
        fifoState == FIFO_FILLING ##1 fifoState == FIFO_RUNNING
            |-> fillCount >= depthNibbles)
        else $error("loopback started below depth");

    chk_fifo_not_past_full: assert property (
        fillCount <= `FIFO_SLOTS and (ce && doRead |=> txNibble.valid))
        else $error("loopback buffer count or output wrong");

    chk_collision_gate: assert property (
        fullDuplex && !fdCollisionEnable |-> !collisionOut)
        else $error("collision shown in full duplex");

    chk_test_int_pin: assert property (
        testInterrupt && pinSelect |-> intPinOut == !interruptPolarity && !intPinOen)
        else $error("forced interrupt missing on pin");

    chk_pin_select_gate: assert property (
        !pinSelect |-> intPinOen && !intPinOut)
        else $error("pin driven while not selected");

    chk_scrambler_bypass: assert property (
        ce && txIn.valid && scramblerBypass |=> txOut.valid && txOut.symbol == $past(txIn.symbol))
        else $error("bypassed symbol altered");

    chk_polarity_idle: assert property (
        pinSelect && !intActive |-> intPinOut == interruptPolarity)
        else $error("interrupt pin idle level wrong");

    cov_loopback_running: cover property (fifoState == FIFO_FILLING ##1 fifoState == FIFO_RUNNING);
    cov_loopback_underrun: cover property (underrun);
    cov_set_and_clear: cover property (writeClear && |evtSet);
    cov_forced_interrupt: cover property (testInterrupt && pinSelect ##1 !testInterrupt);

endmodule

`default_nettype wire

//--- tb/mgmt_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mgmt_host_model (
    input  wire logic                     clk,
    input  wire logic [15:0]              regRdata,
    output var  phy_ctrl_pkg::regReq_type regReq
);
    import phy_ctrl_pkg::*;

    initial regReq = '0;

    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        regReq <= '0;
    endtask

    // data taken mid-cycle, away from the update edge
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        regReq <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk);
        regReq <= '0;
        @(negedge clk);
        d = regRdata;
    endtask
endmodule

`default_nettype wire

//--- tb/phy_specific_control_bits_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_ctrl_defines.svh"

module phy_specific_control_bits_bench;
    import phy_ctrl_pkg::*;

    logic         clk, nrst, ce, loopbackEnable, txNibbleTake, collisionDetect;
    logic         fullDuplex, phyEventIrq, intPinIn, collisionOut, intPinOut;
    logic         intPinOen, powerDownReq, irq;
    logic [15:0]  regRdata, d;
    regReq_type   regReq;
    txSymbol_type txIn, txOut;
    nibble_type   rxNibble, txNibble;
    int           nErrors, checksDone;
    int           depthOf [4] = '{4, 5, 6, 8};
    logic [15:0]  pinCtrl [6] = '{16'h010d, 16'h0105, 16'h0109, 16'h0101, 16'h0104, 16'h010b};
    logic [1:0]   pinExp  [6] = '{2'b00, 2'b01, 2'b01, 2'b00, 2'b10, 2'b00};
    localparam logic [4:0] CTRL = `ADDR_PHY_SPECIFIC_CONTROL;

    phy_specific_control_bits phy_specific_control_bits_i (
        .clk(clk), .nrst(nrst), .ce(ce), .regReq(regReq), .regRdata(regRdata),
        .txIn(txIn), .txOut(txOut), .loopbackEnable(loopbackEnable),
        .rxNibble(rxNibble), .txNibbleTake(txNibbleTake), .txNibble(txNibble),
        .collisionDetect(collisionDetect), .fullDuplex(fullDuplex),
        .collisionOut(collisionOut), .phyEventIrq(phyEventIrq), .intPinIn(intPinIn),
        .intPinOut(intPinOut), .intPinOen(intPinOen), .powerDownReq(powerDownReq), .irq(irq)
    );

    mgmt_host_model mgmt_host_model_i (.clk(clk), .regRdata(regRdata), .regReq(regReq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // generous: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        nErrors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0; ce = 1'b1; loopbackEnable = 1'b0; txNibbleTake = 1'b0;
        collisionDetect = 1'b0; fullDuplex = 1'b0; phyEventIrq = 1'b0; intPinIn = 1'b1;
        txIn = '0; rxNibble = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        mgmt_host_model_i.rd(CTRL, d);
        chk("control reset", 16'h0108, d);
        @(posedge clk) intPinIn <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk) chk("power down", 16'h0001, 16'(powerDownReq));
        @(posedge clk) intPinIn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk) chk("power up", 16'h0000, 16'(powerDownReq));
        $display("test reset done");

        // seed leaves the first key all zero, the second with a single one
        @(posedge clk) txIn <= '{5'h00, 1'b1};
        @(posedge clk);
        @(negedge clk) chk("first symbol", 16'h0001, 16'(txOut));
        @(posedge clk) txIn <= '0;
        @(negedge clk) chk("second key ones", 16'h0001, 16'($countones(txOut.symbol)));
        mgmt_host_model_i.wr(CTRL, 16'h0908);
        @(posedge clk) txIn <= '{5'h15, 1'b1};
        @(posedge clk) txIn <= '0;
        @(negedge clk) chk("bypassed symbol", 16'h002b, 16'(txOut));
        $display("test scrambler done");

        mgmt_host_model_i.wr(CTRL, 16'hffff);
        mgmt_host_model_i.rd(CTRL, d);
        chk("control mask", 16'h0b1f, d);
        mgmt_host_model_i.rd(5'h05, d);
        chk("unmapped read", 16'h0000, d);
        $display("test registers done");

        for (int i = 0; i < 4; i++) begin
            mgmt_host_model_i.wr(CTRL, 16'h0108 | (i[1] ? 16'h0010 : 16'h0000));
            @(posedge clk) fullDuplex <= i[0];
            collisionDetect <= 1'b1;
            @(negedge clk) chk("collision", 16'(!i[0] || i[1]), 16'(collisionOut));
            // hold the collision across one rising edge so the event is seen
            @(posedge clk) collisionDetect <= 1'b0;
        end
        mgmt_host_model_i.rd(`ADDR_EVT_STATUS, d);
        chk("status", 16'h0004, d);
        chk("irq masked", 16'h0000, 16'(irq));
        mgmt_host_model_i.wr(`ADDR_EVT_ENABLE, 16'h0004);
        @(negedge clk) chk("irq raised", 16'h0001, 16'(irq));
        mgmt_host_model_i.wr(`ADDR_EVT_CLEAR, 16'h0004);
        @(negedge clk) chk("irq cleared", 16'h0000, 16'(irq));
        $display("test collision done");

        @(posedge clk) phyEventIrq <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            mgmt_host_model_i.wr(CTRL, pinCtrl[i]);
            @(negedge clk) chk("pin", 16'(pinExp[i]), 16'({intPinOen, intPinOut}));
        end
        @(posedge clk) phyEventIrq <= 1'b0;
        $display("test pin done");

        for (int c = 0; c < 4; c++) begin
            mgmt_host_model_i.wr(CTRL, 16'h0008 | 16'(c << 8));
            @(posedge clk) loopbackEnable <= 1'b1;
            @(posedge clk);
            for (int k = 0; k < depthOf[c] - 1; k++) begin
                rxNibble <= '{4'(k + 1), 1'b1};
                @(posedge clk);
            end
            rxNibble <= '0;
            txNibbleTake <= 1'b1;
            @(posedge clk) txNibbleTake <= 1'b0;
            @(negedge clk) chk("early take", 16'h0000, 16'(txNibble.valid));
            @(posedge clk) rxNibble <= '{4'(depthOf[c]), 1'b1};
            @(posedge clk) rxNibble <= '0;
            txNibbleTake <= 1'b1;
            @(posedge clk) txNibbleTake <= 1'b0;
            @(negedge clk) chk("first nibble", 16'h0003, 16'(txNibble));
            @(posedge clk) loopbackEnable <= 1'b0;
            @(posedge clk);
        end
        $display("test loopback done");

        // a write while the clock enable is low must leave the control word alone
        @(posedge clk) ce <= 1'b0;
        mgmt_host_model_i.wr(CTRL, 16'h0000);
        @(posedge clk) ce <= 1'b1;
        mgmt_host_model_i.rd(CTRL, d);
        chk("frozen write", 16'h0308, d);
        // reset in mid-run brings the control word back to its reset value
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        mgmt_host_model_i.rd(CTRL, d);
        chk("reset again", 16'h0108, d);
        $display("test enable and reset done");
        report_and_stop();
    end
endmodule

`default_nettype wire
